//--- rtl/sadc_top.sv
// Purpose: Control logic of a 12-bit successive approximation converter
// Assumes: Analog comparator and trial DAC outside; RTC values on CLK
// Notes:   Register fields are plain ports; write strobes are one-cycle pulses
// Function
// [RULE1] Linear successive approximation gives a twelve bit result.
// [RULE2] Channel select addresses up to twenty-eight analog inputs.
// [RULE3] Reserved channel codes still convert; the result is undefined.
// [RULE4] Software enables the bandgap buffer before picking the bandgap channel.
// [RULE5] Conversion clock from bus, bus halved, local async or alternate clock.
// [RULE6] Selected source clock is divided by the programmed divider ratio.
// [RULE7] Alternate clock keeps running in wait mode.
// [RULE8] Software avoids alternate clock when converting in stop3.
// [RULE9] Hardware trigger starts a conversion on counter equal to modulo.
// [RULE10] Counter match trigger works with the counter interrupt disabled.
// [RULE11] Counter match trigger works in run, wait and stop3.
// [RULE12] Software sets both low voltage detect enables before stop3 conversions.
// [RULE13] Results are unsigned right justified in twelve, ten or eight bits.
// [RULE14] Single or continuous conversion; single returns to idle.
// [RULE15] Programmable sample time and speed versus power setting.
// [RULE16] Completion flag sets on finish; interrupt when enabled.
// [RULE17] Automatic compare, less-than or greater-or-equal, signals interrupt.
// [RULE18] Exactly two pin enable registers for channels zero to fifteen.
// [RULE19] Status control one write aborts and restarts unless channel all ones; with hardware trigger selected the code waits in idle for a match.
// [RULE20] Channel all ones turns the converter off, no extra conversion.
// [RULE21] Completion flag clears on status control one write or low byte read.
// [RULE22] Codes 0-27 channels, 29 high ref, 30 low ref, 28 reserved; the code also flags 22-25 as reserved.
`timescale 1ns/1ps
`include "sadc_defines.svh"
module sadc_top #(
  parameter int ASYNC_DIV = `SADC_ASYNC_DIV
) (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          STATUS_CONTROL_ONE_WR,
  input  wire logic [`SADC_CH_BITS-1:0]      CHANNEL_SELECT,
  input  wire logic                          CONT_EN,
  input  wire logic                          INT_EN,
  input  wire logic                          RESULT_LOW_BYTE_RD,
  input  wire logic                          HW_TRIGGER_SELECT,
  input  wire logic [`SADC_RTC_BITS-1:0]     REALTIME_COUNT_VALUE,
  input  wire logic [`SADC_RTC_BITS-1:0]     REALTIME_MODULO_VALUE,
  input  wire sadc_pkg::sadc_clk_src_type    CLK_SRC,
  input  wire logic [1:0]                    CONV_CLOCK_DIVIDER,
  input  wire sadc_pkg::sadc_res_mode_type   RES_MODE,
  input  wire logic                          LONG_SAMPLE,
  input  wire logic                          LOW_POWER,
  input  wire logic                          CMP_EN,
  input  wire logic                          CMP_GE,
  input  wire logic [`SADC_RES_BITS-1:0]     CMP_VALUE,
  input  wire logic                          PIN_ENABLE_REG_ONE_WR,
  input  wire logic                          PIN_ENABLE_REG_TWO_WR,
  input  wire logic [7:0]                    PIN_ENABLE_DATA,
  input  wire logic                          EXT_REFERENCE_CLOCK,
  input  wire logic                          COMP_IN,
  output logic      [`SADC_RES_BITS-1:0]     RESULT,
  output logic                               CONV_DONE_FLAG,
  output logic                               IRQ,
  output logic                               CONV_ACTIVE,
  output logic                               SAMPLE_EN,
  output logic                               SAR_POWER_ON,
  output logic      [`SADC_RES_BITS-1:0]     SAR_DAC,
  output logic      [`SADC_CH_BITS-1:0]      ANALOG_MUX_SEL,
  output logic                               RESULT_UNDEFINED,
  output logic      [`SADC_PIN_BITS-1:0]     PIN_CONTROL
);
  import sadc_pkg::*;

  sadc_ce_if ce_if ();

  sadc_clkdiv #(
    .ASYNC_DIV (ASYNC_DIV)
  ) u_clkdiv (
    .CLK (CLK),
    .RST (RST),
    .ce  (ce_if.gen)
  );

  sadc_state_type            state_r;
  logic [`SADC_CH_BITS-1:0]  chan_r;
  logic                      cont_r;
  logic                      int_en_r;
  logic                      ext_s1_r;
  logic                      ext_s2_r;
  logic                      comp_s1_r;
  logic                      comp_s2_r;
  logic                      match_r;
  logic                      hw_trig;
  logic                      lp_phase_r;
  logic                      step;
  logic [7:0]                samp_cnt_r;
  logic [7:0]                samp_last;
  logic [3:0]                bit_r;
  logic [`SADC_RES_BITS-1:0] final_code;
  logic [`SADC_RES_BITS-1:0] fmt_code;
  logic                      cmp_true;
  logic                      finish;
  logic                      flag_set;
  logic                      flag_clr;

  // Both pins leave the CLK domain, so two flops before any use
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
    end
    else
    begin
      ext_s1_r  <= EXT_REFERENCE_CLOCK;
      ext_s2_r  <= ext_s1_r;
      comp_s1_r <= COMP_IN;
      comp_s2_r <= comp_s1_r;
    end
  end

  assign ce_if.src     = CLK_SRC;
  assign ce_if.div     = CONV_CLOCK_DIVIDER;
  assign ce_if.alt_lvl = ext_s2_r;
  assign ce_if.run     = (state_r == SADC_ST_SAMPLE) || (state_r == SADC_ST_CONV);

  // Match taken regardless of the counter interrupt enable, in any power mode
  assign hw_trig = HW_TRIGGER_SELECT
                 && (REALTIME_COUNT_VALUE == REALTIME_MODULO_VALUE)
                 && !match_r; // [RULE9] [RULE10] [RULE11]

  always_ff @(posedge CLK)
  begin
    if (RST)
      match_r <= 1'b0;
    else
      match_r <= (REALTIME_COUNT_VALUE == REALTIME_MODULO_VALUE);
  end

  // Low power doubles each bit period; trades speed for current
  assign step      = ce_if.conv_ce && (!LOW_POWER || lp_phase_r); // [RULE15]
  assign samp_last = LONG_SAMPLE ? `SADC_SAMPLE_LONG : `SADC_SAMPLE_SHORT; // [RULE15]

  // Current bit from the comparator, upper bits already settled in the trial code
  always_comb
  begin
    final_code        = SAR_DAC;
    final_code[bit_r] = comp_s2_r;
  end

  // Right justified, truncating the low bits
  always_comb
  begin
    unique case (RES_MODE)
      SADC_RES_12: fmt_code = final_code; // [RULE1] [RULE13]
      SADC_RES_10: fmt_code = {2'h0, final_code[11:2]}; // [RULE13]
      SADC_RES_8:  fmt_code = {4'h0, final_code[11:4]}; // [RULE13]
      default:     fmt_code = final_code;
    endcase
  end

  assign cmp_true = CMP_GE ? (fmt_code >= CMP_VALUE) : (fmt_code < CMP_VALUE); // [RULE17]
  assign finish   = (state_r == SADC_ST_CONV) && step && (bit_r == 4'h0);
  assign flag_set = finish && (!CMP_EN || cmp_true); // [RULE16] [RULE17]
  assign flag_clr = STATUS_CONTROL_ONE_WR || RESULT_LOW_BYTE_RD; // [RULE21]

  // Status control one contents
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      chan_r   <= `SADC_CH_OFF;
      cont_r   <= 1'b0;
      int_en_r <= 1'b0;
    end
    else if (STATUS_CONTROL_ONE_WR)
    begin
      chan_r   <= CHANNEL_SELECT;
      cont_r   <= CONT_EN;
      int_en_r <= INT_EN;
    end
  end

  // Conversion sequencer
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_r    <= SADC_ST_OFF;
      samp_cnt_r <= 8'h00;
      bit_r      <= `SADC_MSB_INDEX;
      SAR_DAC    <= '0;
      lp_phase_r <= 1'b0;
    end
    else if (STATUS_CONTROL_ONE_WR)
    begin
      samp_cnt_r <= 8'h00;
      lp_phase_r <= 1'b0;
      if (CHANNEL_SELECT == `SADC_CH_OFF)
        state_r <= SADC_ST_OFF; // [RULE20]
      else if (HW_TRIGGER_SELECT)
        state_r <= SADC_ST_IDLE; // [RULE19]
      else
        state_r <= SADC_ST_SAMPLE; // [RULE19]
    end
    else
    begin
      if (ce_if.conv_ce)
        lp_phase_r <= ~lp_phase_r;
      unique case (state_r)
        SADC_ST_OFF:
          state_r <= SADC_ST_OFF; // [RULE20]
        SADC_ST_IDLE:
          if (hw_trig)
          begin
            state_r    <= SADC_ST_SAMPLE;
            samp_cnt_r <= 8'h00;
          end
        SADC_ST_SAMPLE:
          if (step)
          begin
            if (samp_cnt_r >= samp_last - 8'h01)
            begin
              state_r <= SADC_ST_CONV;
              SAR_DAC <= `SADC_MSB_TRIAL;
              bit_r   <= `SADC_MSB_INDEX;
            end
            else
              samp_cnt_r <= samp_cnt_r + 8'h01;
          end
        SADC_ST_CONV:
          if (step)
          begin
            SAR_DAC[bit_r] <= comp_s2_r; // [RULE1]
            if (bit_r != 4'h0)
            begin
              SAR_DAC[bit_r - 4'h1] <= 1'b1;
              bit_r                 <= bit_r - 4'h1;
            end
            else
            begin
              samp_cnt_r <= 8'h00;
              state_r    <= cont_r ? SADC_ST_SAMPLE : SADC_ST_IDLE; // [RULE14]
            end
          end
        default:
          state_r <= SADC_ST_OFF;
      endcase
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      CONV_DONE_FLAG <= 1'b0;
      IRQ            <= 1'b0;
    end
    else
    begin
      CONV_DONE_FLAG <= flag_set || (CONV_DONE_FLAG && !flag_clr); // [RULE16] [RULE21]
      IRQ            <= int_en_r && (flag_set || (CONV_DONE_FLAG && !flag_clr)); // [RULE16]
    end
  end

  // With compare on, only passing results are kept
  always_ff @(posedge CLK)
  begin
    if (RST)
      RESULT <= '0;
    else if (flag_set)
      RESULT <= fmt_code; // [RULE13] [RULE17]
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      CONV_ACTIVE      <= 1'b0;
      SAMPLE_EN        <= 1'b0;
      SAR_POWER_ON     <= 1'b0;
      ANALOG_MUX_SEL   <= `SADC_CH_OFF;
      RESULT_UNDEFINED <= 1'b0;
    end
    else
    begin
      CONV_ACTIVE    <= (state_r == SADC_ST_SAMPLE) || (state_r == SADC_ST_CONV);
      SAMPLE_EN      <= (state_r == SADC_ST_SAMPLE);
      SAR_POWER_ON   <= (state_r == SADC_ST_SAMPLE) || (state_r == SADC_ST_CONV); // [RULE20]
      ANALOG_MUX_SEL <= chan_r; // [RULE2] [RULE22]
      // Reserved codes still convert but the value is meaningless
      RESULT_UNDEFINED <= ((chan_r >= `SADC_CH_RSV_LO) && (chan_r <= `SADC_CH_RSV_HI))
                       || (chan_r == `SADC_CH_RSV_TOP); // [RULE3] [RULE22]
    end
  end

  // Two 8-bit pin enable registers cover channels 0 to 15
  always_ff @(posedge CLK)
  begin
    if (RST)
      PIN_CONTROL <= '0;
    else
    begin
      if (PIN_ENABLE_REG_ONE_WR)
        PIN_CONTROL[7:0] <= PIN_ENABLE_DATA; // [RULE18]
      if (PIN_ENABLE_REG_TWO_WR)
        PIN_CONTROL[15:8] <= PIN_ENABLE_DATA; // [RULE18]
    end
  end

endmodule : sadc_top

//--- rtl/sadc_defines.svh
// Purpose: Named constants for the successive approximation converter control block
// Assumes: Included by bare name from every file that needs a figure
// Notes:   Definitions only
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

`define SADC_RES_BITS        12
`define SADC_CH_BITS         5
`define SADC_RTC_BITS        16
`define SADC_PIN_BITS        16

`define SADC_CH_LAST_PIN     5'h1b
`define SADC_CH_RSV_LO       5'h16
`define SADC_CH_RSV_HI       5'h19
`define SADC_CH_RSV_TOP      5'h1c
`define SADC_CH_REFH         5'h1d
`define SADC_CH_REFL         5'h1e
`define SADC_CH_OFF          5'h1f

`define SADC_SAMPLE_SHORT    8'h04
`define SADC_SAMPLE_LONG     8'h14
`define SADC_ASYNC_DIV       4

`define SADC_MSB_INDEX       4'hb
`define SADC_MSB_TRIAL       12'h800
`define SADC_DIV_BITS        3

`endif

//--- rtl/sadc_pkg.sv
// Purpose: Types shared by the converter control block
// Assumes: Nothing beyond the defines header
// Notes:   Encodings match the mode and clock source fields
package sadc_pkg;

  typedef enum logic [1:0]
  {
    SADC_SRC_BUS     = 2'h0,
    SADC_SRC_BUS_DIV = 2'h1,
    SADC_SRC_ALT     = 2'h2,
    SADC_SRC_ASYNC   = 2'h3
  } sadc_clk_src_type;

  typedef enum logic [1:0]
  {
    SADC_RES_8  = 2'h0,
    SADC_RES_12 = 2'h1,
    SADC_RES_10 = 2'h2
  } sadc_res_mode_type;

  typedef enum logic [3:0]
  {
    SADC_ST_OFF    = 4'h1,
    SADC_ST_IDLE   = 4'h2,
    SADC_ST_SAMPLE = 4'h4,
    SADC_ST_CONV   = 4'h8
  } sadc_state_type;

endpackage : sadc_pkg

//--- rtl/sadc_ce_if.sv
// Purpose: Carrier between the converter control and its conversion clock divider
// Assumes: Single clock domain
// Notes:   alt_lvl is already synchronised by the user side
`timescale 1ns/1ps
interface sadc_ce_if;
  import sadc_pkg::*;
  sadc_clk_src_type src;
  logic [1:0]       div;
  logic             run;
  logic             alt_lvl;
  logic             conv_ce;

  modport gen (input src, input div, input run, input alt_lvl, output conv_ce);
  modport usr (output src, output div, output run, output alt_lvl, input conv_ce);
endinterface : sadc_ce_if

//--- rtl/sadc_clkdiv.sv
// Purpose: Conversion clock enable generator with source select and divider
// Assumes: Alternate clock level arrives synchronised to CLK
// Notes:   Local asynchronous clock is modelled as a free divider of CLK
`timescale 1ns/1ps
`include "sadc_defines.svh"
module sadc_clkdiv #(
  parameter int ASYNC_DIV = `SADC_ASYNC_DIV
) (
  input wire logic CLK,
  input wire logic RST,
  sadc_ce_if.gen   ce
);
  import sadc_pkg::*;

  localparam int AW = (ASYNC_DIV > 1) ? $clog2(ASYNC_DIV) : 1;
  localparam logic [AW-1:0] ASYNC_LAST = AW'(ASYNC_DIV - 1);

  logic                     half_r;
  logic [AW-1:0]            async_cnt_r;
  logic                     alt_prev_r;
  logic                     src_tick;
  logic [`SADC_DIV_BITS-1:0] div_cnt_r;
  logic [`SADC_DIV_BITS-1:0] div_last;
  logic                     ce_r;

  assign div_last   = `SADC_DIV_BITS'((4'h1 << ce.div) - 4'h1);
  assign ce.conv_ce = ce_r;

  // Source tick per selected clock
  always_comb
  begin
    unique case (ce.src)
      SADC_SRC_BUS:     src_tick = 1'b1;
      SADC_SRC_BUS_DIV: src_tick = half_r;
      SADC_SRC_ALT:     src_tick = ce.alt_lvl & ~alt_prev_r;
      SADC_SRC_ASYNC:   src_tick = (async_cnt_r == ASYNC_LAST);
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      half_r      <= 1'b0;
      async_cnt_r <= '0;
      alt_prev_r  <= 1'b0;
    end
    else
    begin
      half_r      <= ~half_r;
      async_cnt_r <= (async_cnt_r == ASYNC_LAST) ? '0 : async_cnt_r + AW'(1);
      alt_prev_r  <= ce.alt_lvl;
    end
  end

  // Divider held cleared while idle so each conversion started from idle or off begins on a fresh phase
  always_ff @(posedge CLK)
  begin
    if (RST || !ce.run)
    begin
      div_cnt_r <= '0;
      ce_r      <= 1'b0;
    end
    else
    begin
      ce_r <= 1'b0;
      if (src_tick)
      begin
        if (div_cnt_r >= div_last)
        begin
          div_cnt_r <= '0;
          ce_r      <= 1'b1; // [RULE5] [RULE6] [RULE7]
        end
        else
        begin
          div_cnt_r <= div_cnt_r + `SADC_DIV_BITS'(1);
        end
      end
    end
  end

endmodule : sadc_clkdiv

//--- verif/sadc_top_assertions.sv
// Purpose: Port level checks of the converter control top
// Assumes: One clock, RST synchronous active high
// Notes:   Bound to sadc_top from the bench top file
`timescale 1ns/1ps
`include "sadc_defines.svh"
module sadc_top_assertions (
  input wire logic                      CLK,
  input wire logic                      RST,
  input wire logic                      STATUS_CONTROL_ONE_WR,
  input wire logic [`SADC_CH_BITS-1:0]  CHANNEL_SELECT,
  input wire logic                      CONT_EN,
  input wire logic                      RESULT_LOW_BYTE_RD,
  input wire logic                      HW_TRIGGER_SELECT,
  input wire logic                      PIN_ENABLE_REG_ONE_WR,
  input wire logic                      PIN_ENABLE_REG_TWO_WR,
  input wire logic [7:0]                PIN_ENABLE_DATA,
  input wire logic                      CONV_DONE_FLAG,
  input wire logic                      IRQ,
  input wire logic                      CONV_ACTIVE,
  input wire logic                      SAMPLE_EN,
  input wire logic                      SAR_POWER_ON,
  input wire logic [`SADC_CH_BITS-1:0]  ANALOG_MUX_SEL,
  input wire logic                      RESULT_UNDEFINED,
  input wire logic [`SADC_PIN_BITS-1:0] PIN_CONTROL
);
  logic [4:0]  ch_r;
  logic [15:0] pin_r;
  logic        cont_r;
  wire         wr = STATUS_CONTROL_ONE_WR;
  wire         pw = PIN_ENABLE_REG_ONE_WR | PIN_ENABLE_REG_TWO_WR;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  function automatic logic rsv(input logic [4:0] c);
    return (c >= `SADC_CH_RSV_LO && c <= `SADC_CH_RSV_HI) || c == `SADC_CH_RSV_TOP;
  endfunction : rsv

  // Shadow of the last write, reset to the off code like the mux
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ch_r   <= `SADC_CH_OFF;
      cont_r <= 1'b0;
    end
    else if (wr)
    begin
      ch_r   <= CHANNEL_SELECT;
      cont_r <= CONT_EN;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      pin_r <= 16'h0000;
    else
    begin
      if (PIN_ENABLE_REG_ONE_WR)
        pin_r[7:0] <= PIN_ENABLE_DATA;
      if (PIN_ENABLE_REG_TWO_WR)
        pin_r[15:8] <= PIN_ENABLE_DATA;
    end
  end

  a_irq_needs_flag:
    assert property (IRQ |-> CONV_DONE_FLAG)
    else $error("irq without completion flag");
  a_write_starts:
    assert property (wr && CHANNEL_SELECT != `SADC_CH_OFF && !HW_TRIGGER_SELECT
      |-> ##[2:3] (CONV_ACTIVE && SAMPLE_EN))
    else $error("write did not start sampling");
  a_off_powers_down:
    assert property (wr && CHANNEL_SELECT == `SADC_CH_OFF ##1 !wr
      |-> ##1 (!CONV_ACTIVE && !SAR_POWER_ON))
    else $error("off code left converter running");
  a_read_clears:
    assert property (RESULT_LOW_BYTE_RD && !CONV_ACTIVE |=> !CONV_DONE_FLAG)
    else $error("low byte read did not clear flag");
  a_undef_tracks:
    assert property ((!wr)[*3] |-> RESULT_UNDEFINED == rsv(ch_r))
    else $error("undefined marker wrong for channel");
  a_mux_tracks:
    assert property ((!wr)[*3] |-> ANALOG_MUX_SEL == ch_r)
    else $error("mux select differs from channel");
  a_pins_track:
    assert property ((!pw)[*2] |-> PIN_CONTROL == pin_r)
    else $error("pin control differs from writes");
  a_single_idles:
    assert property ($rose(CONV_DONE_FLAG) && !cont_r && !HW_TRIGGER_SELECT && !wr
      && !$past(wr) ##1 (!wr)[*2] |-> !CONV_ACTIVE)
    else $error("single conversion did not return to idle");

  c_done: cover property ($rose(CONV_DONE_FLAG));
  c_irq: cover property (IRQ);
  c_hw: cover property (HW_TRIGGER_SELECT && $rose(CONV_ACTIVE));
endmodule : sadc_top_assertions

//--- verif/sadc_top_tb.sv
// Purpose: Self-checking bench for the converter control top
// Assumes: Comparator input held steady through each conversion
// Notes:   Conversion times checked against loose bounds only
`timescale 1ns/1ps
`include "sadc_defines.svh"
module sadc_top_tb;
  import sadc_pkg::*;
  localparam int AD = 4;
  logic              clk, rst, wr, cont, ien, rd, hw, ls, lp, cen, cge, p1, p2, ext, comp;
  logic [4:0]        ch;
  logic [1:0]        dv, ec;
  logic [7:0]        pd;
  logic [11:0]       cv, er;
  logic [15:0]       cnt, mdl;
  sadc_clk_src_type  cs;
  sadc_res_mode_type rm;
  wire  [11:0]       res, dac;
  wire  [4:0]        mux;
  wire  [15:0]       pinc;
  wire               flag, irq, act, pwr, und;
  int                checked, miscompares, n;
  logic [4:0]        cc [9] = '{5'h00, 5'h0f, 5'h15, 5'h16, 5'h19, 5'h1b, 5'h1c, 5'h1d, 5'h1e};
  logic [11:0]       cvl [4] = '{12'h000, 12'h0ff, 12'h100, 12'hfff};

  sadc_top #(.ASYNC_DIV(AD)) dut (
    .CLK(clk), .RST(rst), .STATUS_CONTROL_ONE_WR(wr), .CHANNEL_SELECT(ch),
    .CONT_EN(cont), .INT_EN(ien), .RESULT_LOW_BYTE_RD(rd), .HW_TRIGGER_SELECT(hw),
    .REALTIME_COUNT_VALUE(cnt), .REALTIME_MODULO_VALUE(mdl), .CLK_SRC(cs),
    .CONV_CLOCK_DIVIDER(dv), .RES_MODE(rm), .LONG_SAMPLE(ls), .LOW_POWER(lp),
    .CMP_EN(cen), .CMP_GE(cge), .CMP_VALUE(cv), .PIN_ENABLE_REG_ONE_WR(p1),
    .PIN_ENABLE_REG_TWO_WR(p2), .PIN_ENABLE_DATA(pd), .EXT_REFERENCE_CLOCK(ext),
    .COMP_IN(comp), .RESULT(res), .CONV_DONE_FLAG(flag), .IRQ(irq),
    .CONV_ACTIVE(act), .SAMPLE_EN(), .SAR_POWER_ON(pwr), .SAR_DAC(dac),
    .ANALOG_MUX_SEL(mux), .RESULT_UNDEFINED(und), .PIN_CONTROL(pinc)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Free running reference clock, period of six bus cycles
  always @(posedge clk)
  begin
    ec <= (ec == 2'h2) ? 2'h0 : ec + 2'h1;
    if (ec == 2'h2)
      ext <= ~ext;
    cnt <= cnt + 16'h0001;
  end

  function automatic logic rsv(input logic [4:0] c);
    return (c >= 5'h16 && c <= 5'h19) || c == 5'h1c;
  endfunction : rsv

  // Comparator stuck high keeps every trial bit
  function automatic logic [11:0] fmt(input logic k, input logic [1:0] m);
    if (!k)
      return 12'h000;
    return m == 2'h0 ? 12'h0ff : m == 2'h2 ? 12'h3ff : 12'hfff;
  endfunction : fmt

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic wflag(input int lim, input logic must);
    n = 0;
    while (flag !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (must && n >= lim)
    begin
      miscompares++;
      $display("unexpected timeout waiting for flag");
      print_verdict();
    end
  endtask : wflag

  task automatic wr1(input logic [4:0] c, input logic co);
    @(posedge clk);
    ch <= c;
    cont <= co;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr1

  task automatic rd1;
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask : rd1

  task automatic pin;
    logic [7:0] a;
    logic [7:0] b;
    a = 8'($urandom);
    b = 8'($urandom);
    @(posedge clk);
    pd <= a;
    p1 <= 1'b1;
    @(posedge clk);
    pd <= b;
    p1 <= 1'b0;
    p2 <= 1'b1;
    @(posedge clk);
    p2 <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("pins", pinc, {b, a});
  endtask : pin

  task automatic conv(input logic [4:0] c);
    int f, s, lo, hi;
    logic [1:0] d, m;
    logic l, p, k, e, i;
    logic [11:0] r;
    d = 2'($urandom_range(3));
    m = 2'($urandom_range(3));
    l = 1'($urandom_range(1));
    p = 1'($urandom_range(1));
    k = 1'($urandom_range(1));
    i = 1'($urandom_range(1));
    r = fmt(k, m);
    s = p ? 20 : 4;
    // Caller's settings land at this edge, so read them only after it
    @(posedge clk);
    e = !cen || (cge ? r >= cv : r < cv);
    f = (cs == SADC_SRC_BUS ? 1 : cs == SADC_SRC_BUS_DIV ? 2 : cs == SADC_SRC_ALT ? 6 : AD) << d;
    lo = (s + 12 * (l + 1) - 3) * f;
    hi = ((s + 12) * (l + 1) + 4) * f + 12;
    dv <= d;
    rm <= sadc_res_mode_type'(m);
    lp <= l;
    ls <= p;
    comp <= k;
    ien <= i;
    wr1(c, 1'b0);
    wflag(e ? 2 * hi : hi, e);
    chk("flag", flag, e);
    if (e)
    begin
      er = r;
      chk("time", n >= lo && n <= hi, 1'b1);
    end
    chk("result", res, er);
    chk("dac", dac, {12{k}});
    chk("irq", irq, e & i);
    chk("undef", und, rsv(c));
    chk("mux", mux, c);
    rd1();
    repeat (2) @(posedge clk);
    #1;
    chk("flag clear", flag, 1'b0);
    chk("idle", act, 1'b0);
  endtask : conv

  initial
  begin
    rst = 1'b1;
    {wr, cont, ien, rd, hw, ls, lp, cen, cge, p1, p2, ext, comp} = 13'h0000;
    ch = 5'h1f;
    dv = 2'h0;
    ec = 2'h0;
    pd = 8'h00;
    cv = 12'h000;
    er = 12'h000;
    cnt = 16'h0000;
    mdl = 16'hffff;
    cs = SADC_SRC_BUS;
    rm = SADC_RES_12;
    checked = 0;
    miscompares = 0;
    void'($urandom(32'h237d));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset mux", mux, 5'h1f);
    chk("reset power", pwr, 1'b0);
    repeat (3) pin();
    // Every source is used in run mode only; no stop3 is modelled
    for (int t = 0; t < 4; t++)
    begin
      @(posedge clk);
      cs <= sadc_clk_src_type'(t);
      repeat (5) conv(5'($urandom_range(30)));
    end
    // Code 1b picked only with the bandgap buffer taken as already on
    foreach (cc[j])
      conv(cc[j]);
    for (int j = 0; j < 8; j++)
    begin
      @(posedge clk);
      cen <= 1'b1;
      cge <= 1'(j);
      cv <= cvl[j / 2];
      conv(5'($urandom_range(27)));
    end
    @(posedge clk);
    cen <= 1'b0;
    // Restart in mid conversion, timed from the second write
    wr1(5'h03, 1'b0);
    repeat (4) @(posedge clk);
    conv(5'h04);
    wr1(5'h05, 1'b1);
    wflag(5000, 1'b1);
    rd1();
    chk("cont active", act, 1'b1);
    wflag(5000, 1'b1);
    chk("cont again", flag, 1'b1);
    chk("power", pwr, 1'b1);
    wr1(5'h1f, 1'b1);
    repeat (600) @(posedge clk);
    #1;
    chk("off flag", flag, 1'b0);
    chk("off power", pwr, 1'b0);
    // Match triggers in run mode; stop3 and its voltage detect enables stay unused
    @(posedge clk);
    hw <= 1'b1;
    for (int t = 0; t < 2; t++)
    begin
      @(posedge clk);
      mdl <= cnt + 16'h003c;
      wr1(5'h02, 1'b0);
      repeat (40) @(posedge clk);
      #1;
      chk("no early start", flag, 1'b0);
      wflag(4000, 1'b1);
      chk("match start", flag, 1'b1);
      rd1();
    end
    @(posedge clk);
    hw <= 1'b0;
    print_verdict();
  end
endmodule : sadc_top_tb

bind sadc_top sadc_top_assertions u_chk (
  .CLK                   (CLK),
  .RST                   (RST),
  .STATUS_CONTROL_ONE_WR (STATUS_CONTROL_ONE_WR),
  .CHANNEL_SELECT        (CHANNEL_SELECT),
  .CONT_EN               (CONT_EN),
  .RESULT_LOW_BYTE_RD    (RESULT_LOW_BYTE_RD),
  .HW_TRIGGER_SELECT     (HW_TRIGGER_SELECT),
  .PIN_ENABLE_REG_ONE_WR (PIN_ENABLE_REG_ONE_WR),
  .PIN_ENABLE_REG_TWO_WR (PIN_ENABLE_REG_TWO_WR),
  .PIN_ENABLE_DATA       (PIN_ENABLE_DATA),
  .CONV_DONE_FLAG        (CONV_DONE_FLAG),
  .IRQ                   (IRQ),
  .CONV_ACTIVE           (CONV_ACTIVE),
  .SAMPLE_EN             (SAMPLE_EN),
  .SAR_POWER_ON          (SAR_POWER_ON),
  .ANALOG_MUX_SEL        (ANALOG_MUX_SEL),
  .RESULT_UNDEFINED      (RESULT_UNDEFINED),
  .PIN_CONTROL           (PIN_CONTROL)
);
